// *** hw/dmf_regs.svh ***
// Purpose: Offsets, fields, reset values and timing counts of the DMA mailbox FIFOs
// Assumes: Included by its bare name
// Notes:   Device register indices address 16-bit words
`ifndef DMF_REGS_SVH
`define DMF_REGS_SVH
// Device register indices
`define DMF_A_TXW0      5'h00
`define DMF_A_RXW0      5'h08
`define DMF_A_TXCNT     5'h10
`define DMF_A_RXCNT     5'h11
`define DMF_A_IRQ       5'h12
`define DMF_A_CFG       5'h13
`define DMF_A_BANK      5'h18
// Configuration fields
`define DMF_CFG_DMA     0
`define DMF_CFG_FLYBY   1
`define DMF_CFG_POL     2
`define DMF_CFG_EDGE    3
`define DMF_CFG_RST     4'h5
// Interrupt status and mask fields
`define DMF_IRQ_TXST    0
`define DMF_IRQ_RXST    1
`define DMF_IRQ_TRANSMIT_IRQ_MASK    2
`define DMF_IRQ_RECEIVE_IRQ_MASK    3
`define DMF_IRQ_RST     4'h0
// Counter idle value
`define DMF_CNT_DONE    4'hF
// Controller register byte addresses
`define DMF_H_CTRL      8'h00
`define DMF_H_TXDATA    8'h04
`define DMF_H_RXDATA    8'h08
`define DMF_H_STATUS    8'h0C
// Controller control fields
`define DMF_C_MOTO      0
`define DMF_C_FLYBY     1
`define DMF_C_POL       2
`define DMF_C_HOLD      3
`define DMF_C_RST       5'h04
// Controller timing in hclk cycles
`define DMF_SETUP_CYC   4'h1
`define DMF_STB_CYC     4'h2
`define DMF_GAP_CYC     4'h3
`endif

// *** hw/dmf_pkg.sv ***
// Purpose: Types of the DMA controller end of the DMA mailbox link
// Assumes: Constants come from dmf_regs.svh
// Notes:   No imports; use dmf_pkg::name
package dmf_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RELEASE,
        ST_GAP
    } dmf_ctl_state_t;
endpackage : dmf_pkg

// *** hw/dmf_link_if.sv ***
// Purpose: Strobe, acknowledge, request and data lines between mailbox and DMA controller
// Assumes: One clock; the data bus is split into two one-way byte lanes
// Notes:   Strobes and acknowledge are active low
interface dmf_link_if;
    logic       transfer_acknowledge_in_n;
    logic       rd_n;
    logic       wr_n;
    logic       rw;
    logic       data_strobe_line_n;
    logic [7:0] host_data;
    logic [7:0] dev_data;
    logic       transmit_request_out;
    logic       receive_request_out;

    modport dev (
        input  transfer_acknowledge_in_n, rd_n, wr_n, rw, data_strobe_line_n, host_data,
        output dev_data, transmit_request_out, receive_request_out
    );
    modport ctl (
        output transfer_acknowledge_in_n, rd_n, wr_n, rw, data_strobe_line_n, host_data,
        input  dev_data, transmit_request_out, receive_request_out
    );
endinterface : dmf_link_if

// *** hw/dmf_dev.sv ***
// Purpose: Mailbox end: transmit and receive byte FIFOs, counters, requests, DSP register port
// Assumes: Link inputs synchronous to hclk; a byte is taken when its strobe ends
// Notes:   Counter writes are ignored while a transfer is pending
// Contract
// - Fly-by transfer is one bus transaction
// - Edge mode gives fresh request edge per byte
// - Strobe active drops request, release re-enables it
// - Transmit FIFO sixteen bytes, eight DSP words
// - Transmit counter holds bytes still outstanding; the code holds one less, so 4'hE leaves fifteen bytes to go
// - Shared four-bit interrupt status and mask
// - Transmit count write raises transmit request
// - Memory transmit: acknowledge low, write strobe pulses
// - Second style: read/write low, data strobe times
// - Fly-by swaps strobe meaning at mailbox
// - Each write decrements; done on wrap to F
// - Acknowledge high freezes counter, request stays
// - Count done drops request, raises unmasked interrupt
// - Bytes packed little-endian into words
// - Request polarity chosen by configuration bit
// - Counter not rewritten before transfer done
// - Receive FIFO sixteen bytes, DSP writes words
// - Receive count write raises receive request
// - Memory receive: read strobe pulses, or read/write high
// - Each read decrements; done on wrap to F
// - DSP sees all words, link sees head only; the code reads receive words as zero while DMA is on
// - Configuration bit selects DMA or mailbox extension
//
// The address map and the AHB-Lite register port were decided locally.
`include "dmf_regs.svh"
module dmf_dev (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Link to the DMA controller
    dmf_link_if.dev          link,
    // Bus style strap, high selects data strobe style
    input  wire logic        bus_style_moto,
    // DSP register port
    input  wire logic [4:0]  dsp_addr,
    input  wire logic        dsp_wr,
    input  wire logic        dsp_rd,
    input  wire logic [15:0] dsp_wdata,
    output logic      [15:0] dsp_rdata,
    // DSP interrupt
    output logic             dsp_dma_interrupt
);
    typedef struct packed {
        logic [7:0][15:0] tx_mem;
        logic [7:0][15:0] rx_mem;
        logic [3:0]       tx_cnt;
        logic [3:0]       rx_cnt;
        logic [3:0]       tx_ptr;
        logic [3:0]       rx_ptr;
        logic [3:0]       irq;
        logic [3:0]       cfg;
        logic             tx_act_q;
        logic             rx_act_q;
        logic             ack_q;
        logic [7:0]       byte_q;
        logic             tx_pin;
        logic             rx_pin;
        logic [7:0]       dev_data;
        logic [15:0]      rdata;
        logic             irq_out;
    } dmf_dev_st_t;

    dmf_dev_st_t st_r;
    dmf_dev_st_t st_nxt;

    logic rd_act;
    logic wr_act;
    logic tx_act;
    logic rx_act;
    logic dma_on;
    logic tx_pend;
    logic rx_pend;
    logic tx_take;
    logic rx_take;
    logic tx_lvl;
    logic rx_lvl;
    logic pol;
    logic [4:0] bank;

    always_comb begin
        st_nxt = st_r;
        dma_on = st_r.cfg[`DMF_CFG_DMA];
        pol    = st_r.cfg[`DMF_CFG_POL];
        // Word bank of the DSP index
        bank   = dsp_addr & `DMF_A_BANK;
        // Decode access strobes per bus style
        rd_act = bus_style_moto ? (!link.data_strobe_line_n && link.rw) : !link.rd_n;
        wr_act = bus_style_moto ? (!link.data_strobe_line_n && !link.rw) : !link.wr_n;
        // Fly-by: memory read strobe writes transmit FIFO, memory write reads receive FIFO
        tx_act = st_r.cfg[`DMF_CFG_FLYBY] ? rd_act : wr_act;
        rx_act = st_r.cfg[`DMF_CFG_FLYBY] ? wr_act : rd_act;
        tx_pend = dma_on && (st_r.tx_cnt != `DMF_CNT_DONE);
        rx_pend = dma_on && (st_r.rx_cnt != `DMF_CNT_DONE);
        st_nxt.tx_act_q = tx_act;
        st_nxt.rx_act_q = rx_act;
        st_nxt.ack_q    = !link.transfer_acknowledge_in_n;
        if (tx_act) begin
            st_nxt.byte_q = link.host_data;
        end
        // Access completes at strobe end, only if acknowledge was low
        tx_take = tx_pend && st_r.tx_act_q && !tx_act && st_r.ack_q;
        rx_take = rx_pend && st_r.rx_act_q && !rx_act && st_r.ack_q;
        if (tx_take) begin
            if (st_r.tx_ptr[0]) begin
                st_nxt.tx_mem[st_r.tx_ptr[3:1]][15:8] = st_r.byte_q;
            end else begin
                st_nxt.tx_mem[st_r.tx_ptr[3:1]][7:0] = st_r.byte_q;
            end
            st_nxt.tx_ptr = st_r.tx_ptr + 4'h1;
            st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
            if (st_r.tx_cnt == 4'h0) begin
                st_nxt.irq[`DMF_IRQ_TXST] = 1'b1;
            end
        end
        if (rx_take) begin
            st_nxt.rx_ptr = st_r.rx_ptr + 4'h1;
            st_nxt.rx_cnt = st_r.rx_cnt - 4'h1;
            if (st_r.rx_cnt == 4'h0) begin
                st_nxt.irq[`DMF_IRQ_RXST] = 1'b1;
            end
        end
        // DSP writes
        if (dsp_wr) begin
            if (dsp_addr == `DMF_A_TXCNT) begin
                if (st_r.tx_cnt == `DMF_CNT_DONE) begin
                    st_nxt.tx_cnt = dsp_wdata[3:0];
                    st_nxt.tx_ptr = 4'h0;
                end
            end else if (dsp_addr == `DMF_A_RXCNT) begin
                if (st_r.rx_cnt == `DMF_CNT_DONE) begin
                    st_nxt.rx_cnt = dsp_wdata[3:0];
                    st_nxt.rx_ptr = 4'h0;
                end
            end else if (dsp_addr == `DMF_A_IRQ) begin
                // Write one clears status; a completion in the same cycle wins
                st_nxt.irq[`DMF_IRQ_TRANSMIT_IRQ_MASK] = dsp_wdata[`DMF_IRQ_TRANSMIT_IRQ_MASK];
                st_nxt.irq[`DMF_IRQ_RECEIVE_IRQ_MASK] = dsp_wdata[`DMF_IRQ_RECEIVE_IRQ_MASK];
                if (dsp_wdata[`DMF_IRQ_TXST] && !(tx_take && st_r.tx_cnt == 4'h0)) begin
                    st_nxt.irq[`DMF_IRQ_TXST] = 1'b0;
                end
                if (dsp_wdata[`DMF_IRQ_RXST] && !(rx_take && st_r.rx_cnt == 4'h0)) begin
                    st_nxt.irq[`DMF_IRQ_RXST] = 1'b0;
                end
            end else if (dsp_addr == `DMF_A_CFG) begin
                st_nxt.cfg = dsp_wdata[3:0];
            end else if (bank == `DMF_A_RXW0) begin
                st_nxt.rx_mem[dsp_addr[2:0]] = dsp_wdata;
            end else if (bank == `DMF_A_TXW0 && !dma_on) begin
                // Extension mode: transmit words act as plain mailbox storage
                st_nxt.tx_mem[dsp_addr[2:0]] = dsp_wdata;
            end
        end
        // DSP reads, registered
        if (dsp_rd) begin
            if (bank == `DMF_A_TXW0) begin
                st_nxt.rdata = st_r.tx_mem[dsp_addr[2:0]];
            end else if (bank == `DMF_A_RXW0) begin
                st_nxt.rdata = dma_on ? 16'h0000 : st_r.rx_mem[dsp_addr[2:0]];
            end else if (dsp_addr == `DMF_A_TXCNT) begin
                st_nxt.rdata = {12'h000, st_r.tx_cnt};
            end else if (dsp_addr == `DMF_A_RXCNT) begin
                st_nxt.rdata = {12'h000, st_r.rx_cnt};
            end else if (dsp_addr == `DMF_A_IRQ) begin
                st_nxt.rdata = {12'h000, st_r.irq};
            end else if (dsp_addr == `DMF_A_CFG) begin
                st_nxt.rdata = {12'h000, st_r.cfg};
            end else begin
                st_nxt.rdata = 16'h0000;
            end
        end
        // Link sees only the head byte of the receive FIFO
        st_nxt.dev_data = st_nxt.rx_ptr[0] ? st_nxt.rx_mem[st_nxt.rx_ptr[3:1]][15:8]
                                           : st_nxt.rx_mem[st_nxt.rx_ptr[3:1]][7:0];
        // Request levels; edge mode drops request while a strobe is active
        tx_lvl = st_nxt.cfg[`DMF_CFG_DMA] && (st_nxt.tx_cnt != `DMF_CNT_DONE)
                 && !(st_nxt.cfg[`DMF_CFG_EDGE] && tx_act);
        rx_lvl = st_nxt.cfg[`DMF_CFG_DMA] && (st_nxt.rx_cnt != `DMF_CNT_DONE)
                 && !(st_nxt.cfg[`DMF_CFG_EDGE] && rx_act);
        st_nxt.tx_pin  = tx_lvl ? st_nxt.cfg[`DMF_CFG_POL] : !st_nxt.cfg[`DMF_CFG_POL];
        st_nxt.rx_pin  = rx_lvl ? st_nxt.cfg[`DMF_CFG_POL] : !st_nxt.cfg[`DMF_CFG_POL];
        st_nxt.irq_out = (st_nxt.irq[`DMF_IRQ_TXST] && st_nxt.irq[`DMF_IRQ_TRANSMIT_IRQ_MASK])
                         || (st_nxt.irq[`DMF_IRQ_RXST] && st_nxt.irq[`DMF_IRQ_RECEIVE_IRQ_MASK]);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= '0;
            st_r.tx_cnt <= `DMF_CNT_DONE;
            st_r.rx_cnt <= `DMF_CNT_DONE;
            st_r.cfg    <= `DMF_CFG_RST;
            st_r.irq    <= `DMF_IRQ_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.transmit_request_out = st_r.tx_pin;
    assign link.receive_request_out  = st_r.rx_pin;
    assign link.dev_data             = st_r.dev_data;
    assign dsp_rdata                 = st_r.rdata;
    assign dsp_dma_interrupt         = st_r.irq_out;
    // Variables read only for clarity of decode
    logic unused_pol;
    assign unused_pol = pol;
endmodule : dmf_dev

// *** hw/dmf_ctl.sv ***
// Purpose: DMA controller end: moves one byte per request between registers and the mailbox
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   Transmit has priority; hold bit keeps acknowledge high between bytes
`include "dmf_regs.svh"
module dmf_ctl (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Link to the mailbox
    dmf_link_if.ctl          link
);
    typedef struct packed {
        logic [4:0]              ctrl;
        logic [7:0]              tx_byte;
        logic                    tx_full;
        logic [7:0]              rx_byte;
        logic                    rx_full;
        dmf_pkg::dmf_ctl_state_t state;
        logic                    dir_rx;
        logic [3:0]              tmr;
        logic                    ack_n;
        logic                    rd_n;
        logic                    wr_n;
        logic                    rw;
        logic                    ds_n;
        logic                    wr_pend;
        logic [7:0]              wr_addr;
        logic [31:0]             rdata;
    } dmf_ctl_st_t;

    dmf_ctl_st_t st_r;
    dmf_ctl_st_t st_nxt;

    logic take;
    logic tx_seen;
    logic rx_seen;
    logic use_rd;
    logic strobe;

    always_comb begin
        st_nxt  = st_r;
        take    = hsel && htrans[1] && hready;
        tx_seen = link.transmit_request_out == st_r.ctrl[`DMF_C_POL];
        rx_seen = link.receive_request_out == st_r.ctrl[`DMF_C_POL];
        // Address phase: reads answered from flops in the data phase
        st_nxt.wr_pend = take && hwrite;
        st_nxt.wr_addr = haddr;
        if (take && !hwrite) begin
            case (haddr)
                `DMF_H_CTRL:   st_nxt.rdata = {27'h000_0000, st_r.ctrl};
                `DMF_H_RXDATA: st_nxt.rdata = {24'h00_0000, st_r.rx_byte};
                `DMF_H_STATUS: st_nxt.rdata = {27'h000_0000, st_r.state != dmf_pkg::ST_IDLE,
                                               rx_seen, tx_seen, st_r.rx_full, st_r.tx_full};
                default:       st_nxt.rdata = 32'h0000_0000;
            endcase
            if (haddr == `DMF_H_RXDATA) begin
                st_nxt.rx_full = 1'b0;
            end
        end
        // Transfer sequencer
        st_nxt.tmr = st_r.tmr - 4'h1;
        case (st_r.state)
            dmf_pkg::ST_IDLE: begin
                if (!st_r.ctrl[`DMF_C_HOLD] && tx_seen && st_r.tx_full) begin
                    st_nxt.dir_rx = 1'b0;
                    st_nxt.state  = dmf_pkg::ST_SETUP;
                    st_nxt.tmr    = `DMF_SETUP_CYC;
                end else if (!st_r.ctrl[`DMF_C_HOLD] && rx_seen && !st_r.rx_full) begin
                    st_nxt.dir_rx = 1'b1;
                    st_nxt.state  = dmf_pkg::ST_SETUP;
                    st_nxt.tmr    = `DMF_SETUP_CYC;
                end
            end
            dmf_pkg::ST_SETUP: begin
                if (st_r.tmr == 4'h1) begin
                    st_nxt.state = dmf_pkg::ST_STROBE;
                    st_nxt.tmr   = `DMF_STB_CYC;
                end
            end
            dmf_pkg::ST_STROBE: begin
                if (st_r.tmr == 4'h1) begin
                    st_nxt.state = dmf_pkg::ST_RELEASE;
                    if (st_r.dir_rx) begin
                        st_nxt.rx_byte = link.dev_data;
                        st_nxt.rx_full = 1'b1;
                    end else begin
                        st_nxt.tx_full = 1'b0;
                    end
                end
            end
            dmf_pkg::ST_RELEASE: begin
                st_nxt.state = dmf_pkg::ST_GAP;
                st_nxt.tmr   = `DMF_GAP_CYC;
            end
            dmf_pkg::ST_GAP: begin
                if (st_r.tmr == 4'h1) begin
                    st_nxt.state = dmf_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = dmf_pkg::ST_IDLE;
            end
        endcase
        // Data phase writes; software set of the holding byte wins over the drain
        if (st_r.wr_pend) begin
            if (st_r.wr_addr == `DMF_H_CTRL) begin
                st_nxt.ctrl = hwdata[4:0];
            end else if (st_r.wr_addr == `DMF_H_TXDATA) begin
                st_nxt.tx_byte = hwdata[7:0];
                st_nxt.tx_full = 1'b1;
            end
        end
        // Link lines; fly-by swaps which memory strobe serves the mailbox
        use_rd = st_nxt.dir_rx ^ st_nxt.ctrl[`DMF_C_FLYBY];
        strobe = st_nxt.state == dmf_pkg::ST_STROBE;
        st_nxt.ack_n = !(st_nxt.state == dmf_pkg::ST_SETUP || strobe
                         || st_nxt.state == dmf_pkg::ST_RELEASE);
        st_nxt.rw    = st_nxt.ctrl[`DMF_C_MOTO] ? use_rd : 1'b1;
        st_nxt.ds_n  = !(st_nxt.ctrl[`DMF_C_MOTO] && strobe);
        st_nxt.rd_n  = !(!st_nxt.ctrl[`DMF_C_MOTO] && strobe && use_rd);
        st_nxt.wr_n  = !(!st_nxt.ctrl[`DMF_C_MOTO] && strobe && !use_rd);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r       <= '0;
            st_r.ctrl  <= `DMF_C_RST;
            st_r.state <= dmf_pkg::ST_IDLE;
            st_r.ack_n <= 1'b1;
            st_r.rd_n  <= 1'b1;
            st_r.wr_n  <= 1'b1;
            st_r.rw    <= 1'b1;
            st_r.ds_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata    = st_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign link.transfer_acknowledge_in_n = st_r.ack_n;
    assign link.rd_n               = st_r.rd_n;
    assign link.wr_n               = st_r.wr_n;
    assign link.rw                 = st_r.rw;
    assign link.data_strobe_line_n = st_r.ds_n;
    assign link.host_data          = st_r.tx_byte;
    // Transfer size is always a whole word here
    logic [2:0] unused_hsize;
    assign unused_hsize = hsize;
endmodule : dmf_ctl

// *** test/dmf_props.sv ***
// Purpose: Link checks between the mailbox and the DMA controller
// Assumes: Requests active high
// Notes:   Instantiated beside the link interface
module dmf_props (
    // Clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // Link
    input wire logic       transfer_acknowledge_in_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       rw,
    input wire logic       data_strobe_line_n,
    input wire logic [7:0] host_data,
    input wire logic [7:0] dev_data,
    input wire logic       transmit_request_out,
    input wire logic       receive_request_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic stb_idle;
    assign stb_idle = wr_n && rd_n && data_strobe_line_n;
    reset_idle_a: assert property ($rose(hresetn) |-> !transmit_request_out && !receive_request_out)
        else $error("request active after reset");
    wr_select_a: assert property (!wr_n |-> !transfer_acknowledge_in_n && rd_n)
        else $error("write strobe without select");
    rd_select_a: assert property (!rd_n |-> !transfer_acknowledge_in_n && wr_n)
        else $error("read strobe without select");
    wr_width_a: assert property ($fell(wr_n) |=> !wr_n ##1 wr_n)
        else $error("write strobe width wrong");
    wr_data_a: assert property (!wr_n && !$past(wr_n) |-> $stable(host_data))
        else $error("write data moved in strobe");
    tx_drop_a: assert property ($fell(transmit_request_out) |->
        !$past(stb_idle) || !$past(stb_idle, 2) || !$past(stb_idle, 3))
        else $error("transmit request fell without a byte");
    rx_drop_a: assert property ($fell(receive_request_out) |->
        !$past(stb_idle) || !$past(stb_idle, 2) || !$past(stb_idle, 3))
        else $error("receive request fell without a byte");
    tx_hold_a: assert property (transfer_acknowledge_in_n && transmit_request_out |=> transmit_request_out)
        else $error("transmit request lost while paused");
    rx_head_a: assert property (!rd_n && !$past(rd_n) |-> $stable(dev_data))
        else $error("receive head moved in strobe");
    ack_release_a: assert property ($rose(wr_n) || $rose(rd_n) |-> ##[1:2] transfer_acknowledge_in_n)
        else $error("select not released after byte");
    tx_done_c: cover property ($fell(transmit_request_out));
    rx_done_c: cover property ($fell(receive_request_out));
    paused_c: cover property (transfer_acknowledge_in_n && transmit_request_out [*8]);
endmodule : dmf_props

// *** test/dma_mailbox_fifos_tb.sv ***
// Purpose: Drives both mailbox ends through the DSP port and AHB-Lite
// Assumes: Mailbox starts in reset configuration
// Notes:   Expected values queue up; one monitor compares them
`include "dmf_regs.svh"
module dma_mailbox_fifos_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, dsp_wr, dsp_rd, dsp_dma_interrupt, strobe_style;
    logic [4:0]  dsp_addr;
    logic [15:0] dsp_wdata, dsp_rdata;
    logic        hsel, hwrite, hready, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, seed, seen, rd_v, m;
    logic [31:0] exp_q[$];
    logic [31:0] mask_q[$];
    logic [7:0]  tx_b[16];
    logic [15:0] rx_w[8];
    event        res_ev;
    int          error_cnt, comparisons, cyc;
    dmf_link_if link ();
    dmf_dev i_dmf_dev (.hclk(hclk), .hresetn(hresetn), .link(link), .bus_style_moto(strobe_style), .dsp_addr(dsp_addr),
        .dsp_wr(dsp_wr), .dsp_rd(dsp_rd), .dsp_wdata(dsp_wdata), .dsp_rdata(dsp_rdata),
        .dsp_dma_interrupt(dsp_dma_interrupt));
    dmf_ctl i_dmf_ctl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .link(link));
    dmf_props i_dmf_props (.hclk(hclk), .hresetn(hresetn), .transfer_acknowledge_in_n(link.transfer_acknowledge_in_n),
        .rd_n(link.rd_n), .wr_n(link.wr_n), .rw(link.rw), .data_strobe_line_n(link.data_strobe_line_n),
        .host_data(link.host_data), .dev_data(link.dev_data), .transmit_request_out(link.transmit_request_out),
        .receive_request_out(link.receive_request_out));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // Result seen: monitor takes the oldest note
    task automatic probe(input logic [31:0] v, input logic [31:0] e, input logic [31:0] mk);
        exp_q.push_back(e);
        mask_q.push_back(mk);
        seen = v;
        ->res_ev;
        #1;
    endtask : probe
    always @(res_ev) begin
        m = mask_q.pop_front();
        check(seen & m, exp_q.pop_front() & m);
    end
    task automatic dsp_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge hclk);
        dsp_addr  <= a;
        dsp_wdata <= d;
        dsp_wr    <= 1'b1;
        @(posedge hclk);
        dsp_wr    <= 1'b0;
    endtask : dsp_write
    task automatic dsp_exp(input logic [4:0] a, input logic [31:0] e, input logic [31:0] mk);
        @(posedge hclk);
        dsp_addr <= a;
        dsp_rd   <= 1'b1;
        @(posedge hclk);
        dsp_rd   <= 1'b0;
        #1;
        probe({16'h0000, dsp_rdata}, e, mk);
    endtask : dsp_exp
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_v = hrdata;
    endtask : ahb
    task automatic ahb_exp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
        ahb(1'b0, a, 32'h0000_0000);
        probe(rd_v, e, mk);
    endtask : ahb_exp
    task automatic wait_stat(input int b, input logic v);
        for (int n = 0; n < 50; n++) begin
            ahb(1'b0, `DMF_H_STATUS, 32'h0000_0000);
            if (rd_v[b] === v)
                break;
        end
    endtask : wait_stat

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        int i;
        {hresetn, dsp_wr, dsp_rd, dsp_addr, dsp_wdata, hsel, hwrite, haddr, htrans, hsize, hwdata, strobe_style} = '0;
        error_cnt = 0;
        comparisons = 0;
        cyc = 0;
        seed = 32'h07e5_b4fa;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        dsp_exp(`DMF_A_TXCNT, 32'h0000_000f, 32'hffff_ffff);
        dsp_exp(`DMF_A_RXCNT, 32'h0000_000f, 32'hffff_ffff);
        dsp_exp(`DMF_A_IRQ, 32'h0000_0000, 32'hffff_ffff);
        dsp_exp(`DMF_A_CFG, 32'h0000_0005, 32'hffff_ffff);
        dsp_exp(5'h1f, 32'h0000_0000, 32'hffff_ffff);
        ahb_exp(`DMF_H_CTRL, 32'h0000_0004, 32'hffff_ffff);
        ahb_exp(8'h10, 32'h0000_0000, 32'hffff_ffff);
        // Transmit fifteen bytes, paused in the middle
        dsp_write(`DMF_A_IRQ, 16'h0004);
        ahb(1'b1, `DMF_H_CTRL, 32'h0000_000c);
        dsp_write(`DMF_A_TXCNT, 16'h000e);
        ahb_exp(`DMF_H_STATUS, 32'h0000_0004, 32'h0000_0004);
        ahb(1'b1, `DMF_H_CTRL, 32'h0000_0004);
        for (i = 0; i < 15; i++) begin
            seed = lfsr(seed);
            tx_b[i] = seed[7:0];
            if (i == 4)
                dsp_write(`DMF_A_TXCNT, 16'h0000);
            if (i == 8)
                ahb(1'b1, `DMF_H_CTRL, 32'h0000_000c);
            ahb(1'b1, `DMF_H_TXDATA, {24'h00_0000, tx_b[i]});
            if (i == 8) begin
                repeat (20) @(posedge hclk);
                ahb_exp(`DMF_H_STATUS, 32'h0000_0005, 32'h0000_0005);
                dsp_exp(`DMF_A_TXCNT, 32'h0000_0006, 32'h0000_000f);
                ahb(1'b1, `DMF_H_CTRL, 32'h0000_0004);
            end
            wait_stat(0, 1'b0);
        end
        repeat (4) @(posedge hclk);
        dsp_exp(`DMF_A_TXCNT, 32'h0000_000f, 32'h0000_000f);
        dsp_exp(`DMF_A_IRQ, 32'h0000_0005, 32'h0000_000f);
        probe({31'h0, dsp_dma_interrupt}, 32'h0000_0001, 32'hffff_ffff);
        ahb_exp(`DMF_H_STATUS, 32'h0000_0000, 32'h0000_0004);
        for (i = 0; i < 8; i++)
            dsp_exp(`DMF_A_TXW0 + 5'(i), {16'h0000, tx_b[2*i+1], tx_b[2*i]}, i == 7 ? 32'h00ff : 32'hffff);
        dsp_write(`DMF_A_IRQ, 16'h0005);
        repeat (2) @(posedge hclk);
        #1;
        probe({31'h0, dsp_dma_interrupt}, 32'h0000_0000, 32'hffff_ffff);
        // Receive four bytes
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            rx_w[i] = seed[15:0];
            dsp_write(`DMF_A_RXW0 + 5'(i), rx_w[i]);
        end
        dsp_write(`DMF_A_RXCNT, 16'h0003);
        for (i = 0; i < 4; i++) begin
            wait_stat(1, 1'b1);
            ahb_exp(`DMF_H_RXDATA, {24'h0, i[0] ? rx_w[i/2][15:8] : rx_w[i/2][7:0]}, 32'h00ff);
        end
        repeat (4) @(posedge hclk);
        dsp_exp(`DMF_A_RXCNT, 32'h0000_000f, 32'h0000_000f);
        dsp_exp(`DMF_A_IRQ, 32'h0000_0006, 32'h0000_000f);
        probe({31'h0, dsp_dma_interrupt}, 32'h0000_0000, 32'hffff_ffff);
        dsp_exp(`DMF_A_RXW0, 32'h0000_0000, 32'hffff_ffff);
        // Data strobe style, fly-by, edge requests: two bytes
        dsp_write(`DMF_A_CFG, 16'h000f);
        ahb(1'b1, `DMF_H_CTRL, 32'h0000_0007);
        strobe_style <= 1'b1;
        dsp_write(`DMF_A_TXCNT, 16'h0001);
        for (i = 4; i < 6; i++) begin
            ahb(1'b1, `DMF_H_TXDATA, {24'h00_0000, tx_b[i]});
            wait_stat(0, 1'b0);
        end
        repeat (4) @(posedge hclk);
        dsp_exp(`DMF_A_TXCNT, 32'h0000_000f, 32'h0000_000f);
        dsp_exp(`DMF_A_TXW0, {16'h0000, tx_b[5], tx_b[4]}, 32'h0000_ffff);
        end_sim();
    end
endmodule : dma_mailbox_fifos_tb
